// ### dmacsd_pkg.sv
// package of constants and types for the sync-paced dma channel
package dmacsd_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] DMACSD_CTRL_ADDR = 8'h00;
   localparam logic [7:0] DMACSD_STAT_ADDR = 8'h04;
   localparam logic [7:0] DMACSD_CNT_ADDR = 8'h08;
   localparam logic [7:0] DMACSD_IMSK_ADDR = 8'h0C;
   localparam logic [7:0] DMACSD_ISTS_ADDR = 8'h10;
   // ==========================================================
   // control register fields
   localparam int DMACSD_EN_BIT = 0;
   localparam int DMACSD_AUTO_BIT = 1;
   localparam int DMACSD_RPT_BIT = 2;
   localparam int DMACSD_ENDP_BIT = 3;
   localparam int DMACSD_FIX_BIT = 4;
   localparam int DMACSD_SEL_LSB = 8;
   localparam int DMACSD_SEL_W = 5;
   localparam logic [4:0] DMACSD_SEL_NONE = 5'h00;
   // ==========================================================
   // status register fields
   localparam int DMACSD_ST_SYNC_BIT = 0;
   localparam int DMACSD_ST_DROP_BIT = 1;
   localparam int DMACSD_ST_HANG_BIT = 2;
   localparam int DMACSD_ST_BUSY_BIT = 3;
   // ==========================================================
   // interrupt status bits
   localparam int DMACSD_IRQ_BLK_BIT = 0;
   localparam int DMACSD_IRQ_DROP_BIT = 1;
   localparam int DMACSD_IRQ_HANG_BIT = 2;
   localparam int DMACSD_IRQ_W = 3;
   // ==========================================================
   // sizes and timing
   localparam int DMACSD_CNT_W = 16;
   localparam int DMACSD_NSRC = 32;
   localparam logic [15:0] DMACSD_CNT_RST = 16'h0014;
   localparam logic [3:0] DMACSD_XFER_CYC = 4'h3;
   localparam logic [1:0] DMACSD_HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {DMACSD_IDLE, DMACSD_WAIT, DMACSD_XFER,
      DMACSD_HUNG} dmacsd_state_t;
endpackage

// ### dmacsd_sync_sel.sv
// selects and edge-detects the chosen sync event
`timescale 1ns/10ps
module dmacsd_sync_sel
   import dmacsd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [DMACSD_NSRC-1:0] sync_src,
   input wire logic [DMACSD_SEL_W-1:0] sel,
   output logic sync_pulse
);
   logic lvl_ff;
   logic cur;

   // select code zero means no sync pacing, so no event is ever seen
   always_comb
   begin
      cur = (sel != DMACSD_SEL_NONE) && sync_src[sel];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lvl_ff <= 1'b0;
      end
      else
      begin
         lvl_ff <= cur;
      end
   end

   assign sync_pulse = cur && !lvl_ff;
endmodule

// ### dmacsd_xfer.sv
// models one element's port read and write as a fixed busy interval
`timescale 1ns/10ps
module dmacsd_xfer
   import dmacsd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   output logic busy,
   output logic done
);
   logic [3:0] cnt_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_ff <= 4'h0;
      end
      else if (start && cnt_ff == 4'h0)
      begin
         cnt_ff <= DMACSD_XFER_CYC;
      end
      else if (cnt_ff != 4'h0)
      begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end

   assign busy = cnt_ff != 4'h0;
   assign done = cnt_ff == 4'h1;
endmodule

// ### dmacsd_top.sv
// sync-paced dma channel control with enable, hang and recovery logic
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module dmacsd_top
   import dmacsd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [DMACSD_NSRC-1:0] sync_src,
   output logic elem_req,
   output logic irq
);
   // ==========================================================
   // registers
   logic en_ff, auto_ff, rpt_ff, endp_ff, fix_ff;
   logic [DMACSD_SEL_W-1:0] sel_ff;
   logic [DMACSD_CNT_W-1:0] cnt_cfg_ff, left_ff;
   logic sync_st_ff, drop_ff;
   logic [DMACSD_IRQ_W-1:0] ists_ff, imsk_ff;
   dmacsd_state_t st_ff;
   logic wr_pend_ff;
   logic [7:0] wa_ff;
   logic [31:0] hrdata_ff;
   logic irq_ff, elem_req_ff;
   logic sync_pulse, xbusy, xdone, start;
   logic ctrl_wr, ists_wr, block_end, hang_ev, drop_ev, reload;
   logic [DMACSD_IRQ_W-1:0] ev;

   dmacsd_sync_sel u_sel (
      .hclk(hclk),
      .hresetn(hresetn),
      .sync_src(sync_src),
      .sel(sel_ff),
      .sync_pulse(sync_pulse)
   );

   dmacsd_xfer u_xfer (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(start),
      .busy(xbusy),
      .done(xdone)
   );

   // ==========================================================
   // ahb-lite slave: zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         wa_ff <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_ff <= hsel && htrans == DMACSD_HTRANS_NONSEQ && hwrite;
         wa_ff <= haddr[7:0];
      end
   end

   assign ctrl_wr = wr_pend_ff && wa_ff == DMACSD_CTRL_ADDR;
   assign ists_wr = wr_pend_ff && wa_ff == DMACSD_ISTS_ADDR;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff <= 32'h0000_0000;
      end
      else if (hready && hsel && htrans == DMACSD_HTRANS_NONSEQ && !hwrite)
      begin
         unique case (haddr[7:0])
            DMACSD_CTRL_ADDR: hrdata_ff <= {19'h0, sel_ff, 3'h0, fix_ff,
               endp_ff, rpt_ff, auto_ff, en_ff};
            // sync bit latches each event seen outside idle and clears when an element transfer completes or the select is cleared
            DMACSD_STAT_ADDR: hrdata_ff <= {28'h0, xbusy,
               st_ff == DMACSD_HUNG, drop_ff, sync_st_ff};
            DMACSD_CNT_ADDR: hrdata_ff <= {left_ff, cnt_cfg_ff};
            DMACSD_IMSK_ADDR: hrdata_ff <= {29'h0, imsk_ff};
            DMACSD_ISTS_ADDR: hrdata_ff <= {29'h0, ists_ff};
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_cfg_ff <= DMACSD_CNT_RST;
         imsk_ff <= 3'h0;
      end
      else if (wr_pend_ff)
      begin
         if (wa_ff == DMACSD_CNT_ADDR)
            cnt_cfg_ff <= hwdata[DMACSD_CNT_W-1:0];
         if (wa_ff == DMACSD_IMSK_ADDR)
            imsk_ff <= hwdata[DMACSD_IRQ_W-1:0];
      end
   end

   // ==========================================================
   // channel sequencing
   // with fix clear the old flaw is kept so software recovery can be tested
   assign block_end = xdone && left_ff == 16'h0001;
   assign reload = auto_ff && (rpt_ff || endp_ff);
   // a sync during the final element, before the self-disable, is the flaw
   assign hang_ev = sync_pulse && !fix_ff && ((st_ff == DMACSD_XFER
      && left_ff == 16'h0001 && !reload)
      || (st_ff == DMACSD_WAIT && left_ff == 16'h0000));
   // without reload, the late sync of the final element never counts as dropped
   assign drop_ev = sync_pulse && st_ff == DMACSD_XFER
      && (left_ff != 16'h0001 || reload);
   assign start = st_ff == DMACSD_WAIT && sync_pulse && left_ff != 16'h0000;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff <= DMACSD_IDLE;
         left_ff <= 16'h0000;
         en_ff <= 1'b0;
         auto_ff <= 1'b0;
         rpt_ff <= 1'b0;
         endp_ff <= 1'b0;
         fix_ff <= 1'b0;
         sel_ff <= DMACSD_SEL_NONE;
      end
      else
      begin
         if (ctrl_wr)
         begin
            en_ff <= hwdata[DMACSD_EN_BIT];
            auto_ff <= hwdata[DMACSD_AUTO_BIT];
            rpt_ff <= hwdata[DMACSD_RPT_BIT];
            endp_ff <= hwdata[DMACSD_ENDP_BIT];
            fix_ff <= hwdata[DMACSD_FIX_BIT];
            sel_ff <= hwdata[DMACSD_SEL_LSB +: DMACSD_SEL_W];
         end
         unique case (st_ff)
            DMACSD_IDLE:
               if (ctrl_wr && hwdata[DMACSD_EN_BIT])
               begin
                  st_ff <= DMACSD_WAIT;
                  left_ff <= cnt_cfg_ff;
               end
            DMACSD_WAIT:
               if (ctrl_wr && !hwdata[DMACSD_EN_BIT])
                  st_ff <= DMACSD_IDLE;
               else if (hang_ev)
                  st_ff <= DMACSD_HUNG;
               else if (start)
                  st_ff <= DMACSD_XFER;
            DMACSD_XFER:
               if (hang_ev)
                  st_ff <= DMACSD_HUNG;
               else if (xdone)
               begin
                  left_ff <= left_ff - 16'h0001;
                  if (!block_end)
                     st_ff <= DMACSD_WAIT;
                  else if (auto_ff && (rpt_ff || endp_ff))
                  begin
                     st_ff <= DMACSD_WAIT;
                     left_ff <= cnt_cfg_ff;
                     endp_ff <= 1'b0;
                  end
                  else
                     st_ff <= DMACSD_WAIT;
               end
            DMACSD_HUNG:
               // only clearing the sync select frees the channel
               if (ctrl_wr && hwdata[DMACSD_SEL_LSB +: DMACSD_SEL_W]
                  == DMACSD_SEL_NONE)
                  st_ff <= DMACSD_IDLE;
         endcase
         // final element done and no reload: enable drops by itself
         if (st_ff == DMACSD_XFER && block_end && !reload && !hang_ev)
         begin
            en_ff <= 1'b0;
            st_ff <= DMACSD_IDLE;
         end
         // a hung channel still shows its enable cleared
         if (hang_ev)
            en_ff <= 1'b0;
         // late sync with fix set is simply dropped here
      end
   end

   // ==========================================================
   // status flags: set wins over clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_st_ff <= 1'b0;
         drop_ff <= 1'b0;
      end
      else
      begin
         if (sync_pulse && (st_ff != DMACSD_IDLE || hang_ev))
            sync_st_ff <= 1'b1;
         else if (ctrl_wr && hwdata[DMACSD_SEL_LSB +: DMACSD_SEL_W]
            == DMACSD_SEL_NONE)
            sync_st_ff <= 1'b0;
         else if (st_ff == DMACSD_XFER && xdone && st_ff != DMACSD_HUNG)
            sync_st_ff <= 1'b0;
         if (drop_ev)
            drop_ff <= 1'b1;
         else if (ctrl_wr && hwdata[DMACSD_EN_BIT])
            drop_ff <= 1'b0;
      end
   end

   // ==========================================================
   // interrupts: write one to clear, set wins
   assign ev = {hang_ev, drop_ev, block_end && st_ff == DMACSD_XFER};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ists_ff <= 3'h0;
         irq_ff <= 1'b0;
         elem_req_ff <= 1'b0;
      end
      else
      begin
         ists_ff <= ev | (ists_ff & ~({DMACSD_IRQ_W{ists_wr}}
            & hwdata[DMACSD_IRQ_W-1:0]));
         irq_ff <= |(ists_ff & imsk_ff);
         elem_req_ff <= xbusy;
      end
   end

   assign irq = irq_ff;
   assign elem_req = elem_req_ff;
endmodule

// ### dmacsd_periph.sv
// model of the peripheral that raises sync events
`timescale 1ns/10ps
module dmacsd_periph
   import dmacsd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic fire,
   input wire logic [4:0] idx,
   output logic [DMACSD_NSRC-1:0] sync_src
);
   // =====
   // one-cycle pulse; lines are pulled low between events
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sync_src <= '0;
      else
         sync_src <= fire ? 32'h1 << idx : 32'h0;
   end
endmodule

// ### dmacsd_sva.sv
// assertion checker on the dma channel top ports
`timescale 1ns/10ps
module dmacsd_sva
   import dmacsd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [DMACSD_NSRC-1:0] sync_src,
   input wire logic elem_req,
   input wire logic irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // =====
   // ages of the last sync edge and of the last event
   logic [31:0] prev_ff;
   logic er_ff;
   logic [3:0] sage_ff;
   logic [3:0] eage_ff;
   wire tk = hsel && hready && htrans == 2'h2;
   wire s_rise = |(sync_src & ~prev_ff);
   wire evt = s_rise || (tk && hwrite) || (er_ff && !elem_req);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev_ff <= '0;
         er_ff <= 1'b0;
         sage_ff <= 4'hF;
         eage_ff <= 4'hF;
      end
      else
      begin
         prev_ff <= sync_src;
         er_ff <= elem_req;
         sage_ff <= s_rise ? 4'h0 : sage_ff + {3'h0, sage_ff != 4'hF};
         eage_ff <= evt ? 4'h0 : eage_ff + {3'h0, eage_ff != 4'hF};
      end
   end
   sequence s_busy;
      elem_req [*3] ##1 !elem_req;
   endsequence
   a_elem_len: assert property ($rose(elem_req) |-> s_busy)
      else $error("element transfer length wrong");
   a_req_cause: assert property ($rose(elem_req) |-> sage_ff <= 4'h4)
      else $error("element started without a sync event");
   a_irq_cause: assert property ($changed(irq) |-> eage_ff <= 4'h6)
      else $error("irq moved without a cause");
   a_okay_resp: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_ready_high: assert property (hreadyout)
      else $error("wait state inserted");
   a_rd_stands: assert property ($changed(hrdata) |-> $past(tk && !hwrite))
      else $error("read data moved without a read");
   a_write_keeps: assert property (tk && hwrite |=> $stable(hrdata))
      else $error("write disturbed read data");
   a_unmapped_zero: assert property (tk && !hwrite && haddr == 32'h20
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind dmacsd_top dmacsd_sva chk_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sync_src(sync_src), .elem_req(elem_req), .irq(irq));

// ### dmacsd_bench.sv
// self-checking bench for the sync-paced dma channel
`timescale 1ns/10ps
module dmacsd_bench
   import dmacsd_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, fire, hreadyout, hresp, elem_req, irq;
   logic er_q = 1'b0;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [DMACSD_NSRC-1:0] sync_src;
   logic [1:0] htrans;
   logic [4:0] idx;
   logic [72:0] rows [12];
   int miscompares, n_compared, rises, r0, cyc;
   dmacsd_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sync_src(sync_src),
      .elem_req(elem_req), .irq(irq));
   dmacsd_periph per (.hclk(hclk), .hresetn(hresetn), .fire(fire),
      .idx(idx), .sync_src(sync_src));
   // =====
   // bus, stimulus and check tasks
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
         miscompares++;
      end
   endtask
   task pulse(input int n, input int gap);
      repeat (n)
      begin
         @(posedge hclk);
         fire <= 1'b1;
         @(posedge hclk);
         fire <= 1'b0;
         repeat (gap) @(posedge hclk);
      end
   endtask
   task go(input logic [31:0] cnt, input logic [31:0] ctl);
      bus(1'b1, 8'h08, cnt);
      bus(1'b1, 8'h00, ctl);
      r0 = rises;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // rising edges of elem_req count moved elements
   always @(posedge hclk)
   begin
      if (elem_req && !er_q)
         rises++;
      er_q <= elem_req;
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         summarize;
      end
   end
   initial
   begin
      {hresetn, hsel, hwrite, fire, htrans, haddr, hwdata} = '0;
      idx = 5'h01;
      rows = '{{1'b0, 8'h00, 32'h0, 32'hFFFFFFFF}, {1'b0, 8'h04, 32'h0, 32'hF},
         {1'b0, 8'h08, 32'h14, 32'hFFFF}, {1'b0, 8'h0C, 32'h0, 32'h7},
         {1'b0, 8'h10, 32'h0, 32'h7}, {1'b0, 8'h20, 32'h0, 32'hFFFFFFFF},
         {1'b1, 8'h08, 32'h4, 32'h0}, {1'b1, 8'h0C, 32'h7, 32'h0},
         {1'b1, 8'h20, 32'h5, 32'h0}, {1'b0, 8'h08, 32'h4, 32'hFFFF},
         {1'b0, 8'h0C, 32'h7, 32'h7}, {1'b0, 8'h20, 32'h0, 32'hFFFFFFFF}};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i])
      begin
         bus(rows[i][72], rows[i][71:64], rows[i][63:32]);
         if (!rows[i][72])
            chk(q & rows[i][31:0], rows[i][63:32]);
      end
      go(32'h4, 32'h101);
      pulse(4, 8);
      chk(rises - r0, 4);
      rd(8'h00, 32'h1, 32'h0);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 8'h10, 32'h7);
      bus(1'b1, 8'h0C, 32'h0);
      go(32'h2, 32'h101);
      pulse(2, 1);
      pulse(1, 8);
      chk(rises - r0, 2);
      rd(8'h04, 32'h2, 32'h2);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h0C, 32'h2);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 8'h10, 32'h7);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      go(32'h4, 32'h101);
      pulse(3, 8);
      pulse(2, 1);
      rd(8'h04, 32'h7, 32'h5);
      rd(8'h00, 32'h1, 32'h0);
      pulse(1, 8);
      chk(rises - r0, 4);
      bus(1'b1, 8'h00, 32'h0);
      go(32'h1, 32'h101);
      pulse(1, 8);
      chk(rises - r0, 1);
      go(32'h4, 32'h111);
      pulse(3, 8);
      pulse(2, 1);
      rd(8'h04, 32'h4, 32'h0);
      go(32'h1, 32'h111);
      pulse(1, 8);
      chk(rises - r0, 1);
      go(32'h1, 32'h103);
      pulse(2, 8);
      chk(rises - r0, 1);
      go(32'h1, 32'h10B);
      pulse(3, 8);
      chk(rises - r0, 2);
      go(32'h1, 32'h107);
      pulse(2, 8);
      chk(rises - r0, 2);
      bus(1'b1, 8'h00, 32'h103);
      pulse(2, 8);
      chk(rises - r0, 3);
      rd(8'h00, 32'h1, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h08, 32'hFFFF, 32'h14);
      summarize;
   end
endmodule
